// >>> hw/odf_cic.sv
/*
  odf_cic: one channel, third-order integrate-and-comb decimator.
  Assumes the strobes of odf_tick_if come from one shared sequencer.
*/
`timescale 1ns/1ps
module odf_cic (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // shared strobes
  odf_tick_if.filt tk,
  // modulator bit and decimated word
  input wire logic mod_bit,
  output logic signed [23:0] result
);
  import odf_pkg::*;

  logic signed [23:0] int1, int2, int3;
  logic signed [23:0] dly1, dly2, dly3;
  logic signed [23:0] comb1, comb2, comb3;
  logic signed [23:0] step;

  // a one is +1, a zero is -1
  assign step = mod_bit ? 24'sh000001 : 24'shffffff;

  // integrators run at the modulator rate; wrapping is harmless here
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int1 <= '0;
      int2 <= '0;
      int3 <= '0;
    end else if (tk.clear) begin
      int1 <= '0;
      int2 <= '0;
      int3 <= '0;
    end else if (tk.mod_tick) begin // [R19]
      int1 <= int1 + step;
      int2 <= int2 + int1;
      int3 <= int3 + int2;
    end
  end

  // combs evaluated once per output period
  assign comb1 = int3 - dly1;
  assign comb2 = comb1 - dly2;
  assign comb3 = comb2 - dly3;

  // comb delays and held result
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dly1 <= '0;
      dly2 <= '0;
      dly3 <= '0;
      result <= '0;
    end else if (tk.clear) begin
      dly1 <= '0;
      dly2 <= '0;
      dly3 <= '0;
      result <= '0;
    end else if (tk.out_tick) begin // [R1] [R2]
      dly1 <= int3;
      dly2 <= comb1;
      dly3 <= comb2;
      result <= comb3;
    end
  end
endmodule : odf_cic

// >>> hw/odf_filter.sv
/*
  odf_filter: eight-channel decimation filter with an Avalon-MM slave.
  Result words read as zero while the delay ring first fills.
  Assumes MOD_BITS are synchronous to CLK and valid at each modulator
  tick; the master follows Avalon-MM waitrequest signalling.
*/
// Functional notes
// R1: three modes share filter, decimate by 64
// R2: high-resolution mode decimates by 128
// R3: linear phase, constant delay at all frequencies
// R4: step barely changes output before period thirty
// R5: step settled after 76 periods, 64-times modes
// R6: step settled after 78 periods, high resolution
// R7: 24-bit two's-complement result words
// R8: positive full scale gives 7fffff
// R9: negative full scale gives 800000
// R10: out-of-range inputs clip, never wrap
// R11: modulator divisor from mode and divide select
// R12: sample period follows the selected divisor
// R13: stop band attenuates up to modulator rate
// R14: response repeats at modulator-rate multiples
// R15: mode codes 00, 01, 10, 11 followed continuously
// R16: restart low halts and clears counters
// R17: all channels start on same modulator tick
// R18: clocks per word 256, 512 or 2560
// R19: one sample per tick, results update together
// R20: mode or divide change restarts and resettles
`timescale 1ns/1ps
module odf_filter (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // avalon-mm slave
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // modulator streams, one bit per channel
  input wire logic [odf_pkg::ODF_CHANNELS-1:0] MOD_BITS,
  // status pins
  output logic RESULT_STROBE,
  output logic SETTLED
);
  import odf_pkg::*;

  // modulator divisor for a mode and divide select
  function automatic logic [5:0] mod_div(input odf_mode_t m,
                                         input logic dv);
    case (m)
      ODF_LOW_POWER_SETTING: mod_div = dv ? ODF_DIV_MID : ODF_DIV_FAST;
      ODF_LOW_SPEED_SETTING: mod_div = dv ? ODF_DIV_SLOW : ODF_DIV_MID;
      default: mod_div = ODF_DIV_FAST;
    endcase
  endfunction : mod_div

  // high-resolution mode doubles the ratio and lengthens settling
  function automatic logic is_hires(input odf_mode_t m);
    is_hires = (m == ODF_HIGH_RESOLUTION_SETTING);
  endfunction : is_hires

  // scale a comb output to full scale and clip at the extreme codes
  function automatic logic [23:0] sat_scale(input logic [23:0] v,
                                            input logic [2:0] sh);
    logic signed [31:0] wide;
    wide = 32'(signed'(v)) <<< sh;
    if (wide > 32'(signed'(ODF_POS_FULL)))
      sat_scale = ODF_POS_FULL;
    else if (wide < -32'sh00800000)
      sat_scale = ODF_NEG_FULL;
    else
      sat_scale = wide[23:0];
  endfunction : sat_scale

  odf_tick_if tk ();

  logic [3:0] ctrl;
  odf_mode_t mode;
  logic div_sel;
  logic run;
  logic [5:0] div_cnt;
  logic [7:0] smp_cnt;
  logic [5:0] cur_div;
  logic [7:0] cur_osr;
  logic [6:0] settle_tgt;
  logic [6:0] ring_len;
  logic [2:0] cur_shift;
  logic restart;
  logic mod_tick;
  logic out_tick;
  logic [6:0] settle_cnt;
  logic [6:0] ring_ptr;
  odf_seq_t seq;
  logic [2:0] seq_ch;
  logic [23:0] cic_out [ODF_CHANNELS];
  logic [23:0] ring [ODF_CHANNELS*128];
  logic [23:0] stage [ODF_CHANNELS];
  logic [23:0] result [ODF_CHANNELS];
  logic [23:0] ring_rd;
  logic fresh;
  logic word_done;
  logic status_rd;
  logic access;
  logic ctrl_wr;
  logic [3:0] next_ctrl;
  logic [31:0] next_rdata;

  // current settings taken from the control register
  assign mode = odf_mode_t'(ctrl[ODF_CTRL_MODE_LSB +: 2]); // [R15]
  assign div_sel = ctrl[ODF_CTRL_DIV_BIT];
  assign run = ctrl[ODF_CTRL_RUN_BIT];
  assign cur_div = mod_div(mode, div_sel); // [R11] [R12]
  assign cur_osr = is_hires(mode) ?
                   ODF_OSR_HIRES : ODF_OSR_BASE; // [R1] [R2]
  assign settle_tgt = is_hires(mode) ?
                      ODF_SETTLE_HIRES : ODF_SETTLE_BASE; // [R5] [R6]
  assign cur_shift = is_hires(mode) ?
                     ODF_SHIFT_HIRES : ODF_SHIFT_BASE;
  // pure delay added after the combs, so total settling hits the target;
  // the integrators lag two ticks, so the combs need four whole words
  assign ring_len = settle_tgt - ODF_CIC_SPAN; // [R3] [R4]

  // bus handshake terms
  assign access = (AVS_READ | AVS_WRITE) & ~AVS_WAITREQUEST;
  assign ctrl_wr = access & AVS_WRITE & AVS_BYTEENABLE[0] &
                   (AVS_ADDRESS == ODF_CTRL_OFS);
  assign next_ctrl = ctrl_wr ? AVS_WRITEDATA[3:0] : ctrl;

  // events behind the strobe and the fresh flag
  assign word_done = (seq == ODF_COMMIT) & ~restart;
  assign status_rd = access & AVS_READ & (AVS_ADDRESS == ODF_STATUS_OFS);

  // restart on halt or on a write that changes the mode or divide select
  assign restart = ~run |
                   (ctrl_wr & (next_ctrl[2:0] != ctrl[2:0])); // [R16] [R20]

  // strobes shared by all channels
  assign mod_tick = run & (div_cnt == cur_div - 6'h01);
  assign out_tick = mod_tick & (smp_cnt == cur_osr - 8'h01);
  assign tk.mod_tick = mod_tick; // [R17]
  assign tk.out_tick = out_tick;
  assign tk.clear = restart;

  // control register
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl <= ODF_CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // modulator-rate divider of the master clock
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_cnt <= '0;
    end else if (restart || mod_tick) begin // [R11] [R16]
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 6'h01;
    end
  end

  // samples per output word; divisor times ratio gives the word period
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      smp_cnt <= '0;
    end else if (restart || out_tick) begin // [R18]
      smp_cnt <= '0;
    end else if (mod_tick) begin
      smp_cnt <= smp_cnt + 8'h01;
    end
  end

  // one decimator per channel, all on the same strobes
  for (genvar c = 0; c < ODF_CHANNELS; c++) begin : g_ch // [R13] [R14]
    odf_cic u_cic (
      .clk(CLK),
      .reset_n(RESET_N),
      .tk(tk.filt),
      .mod_bit(MOD_BITS[c]),
      .result(cic_out[c])
    );
  end

  // sequencer walks the channels through the delay ring
  // eight walk cycles and a commit fit well inside one word period
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      seq <= ODF_IDLE;
      seq_ch <= '0;
    end else if (restart) begin
      seq <= ODF_IDLE;
      seq_ch <= '0;
    end else begin
      case (seq)
        ODF_IDLE: begin
          if (out_tick) begin
            seq <= ODF_WALK;
          end
        end
        ODF_WALK: begin
          seq_ch <= seq_ch + 3'h1;
          if (seq_ch == 3'h7) begin
            seq <= ODF_COMMIT;
          end
        end
        ODF_COMMIT: begin
          seq <= ODF_IDLE;
        end
        default: begin
          seq <= ODF_IDLE;
        end
      endcase
    end
  end

  // delay ring: read the oldest word, then overwrite it
  always_ff @(posedge CLK) begin
    if (seq == ODF_WALK) begin
      ring_rd <= ring[{seq_ch, ring_ptr}];
      ring[{seq_ch, ring_ptr}] <= cic_out[seq_ch]; // [R3]
    end
  end

  // staging of delayed words; scaling and clipping come at the commit
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < ODF_CHANNELS; i++) begin
        stage[i] <= '0;
      end
    end else if (seq == ODF_WALK && seq_ch != 3'h0) begin
      stage[seq_ch - 3'h1] <= ring_rd;
    end else if (seq == ODF_COMMIT) begin
      stage[ODF_CHANNELS-1] <= ring_rd;
    end
  end

  // ring pointer advances once per committed word
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ring_ptr <= '0;
    end else if (restart) begin
      ring_ptr <= '0;
    end else if (seq == ODF_COMMIT) begin
      ring_ptr <= (ring_ptr >= ring_len - 7'h01) ? 7'h00 :
                  ring_ptr + 7'h01;
    end
  end

  // output periods since restart, held at the target
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      settle_cnt <= '0;
    end else if (restart) begin
      settle_cnt <= '0; // [R20]
    end else if (seq == ODF_COMMIT && settle_cnt != settle_tgt) begin
      settle_cnt <= settle_cnt + 7'h01;
    end
  end

  // all channel results change on one edge; unfilled ring reads as zero
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < ODF_CHANNELS; i++) begin
        result[i] <= '0;
      end
    end else if (seq == ODF_COMMIT) begin // [R19]
      for (int i = 0; i < ODF_CHANNELS - 1; i++) begin
        result[i] <= (settle_cnt < ring_len) ? 24'h000000 :
                     sat_scale(stage[i], cur_shift); // [R7] [R10]
      end
      result[ODF_CHANNELS-1] <= (settle_cnt < ring_len) ? 24'h000000 :
                                sat_scale(ring_rd, cur_shift); // [R8] [R9]
    end
  end

  // strobe and settled pins
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RESULT_STROBE <= 1'b0;
      SETTLED <= 1'b0;
    end else begin
      RESULT_STROBE <= word_done;
      SETTLED <= ~restart & (settle_cnt == settle_tgt); // [R5] [R6]
    end
  end

  // fresh flag: a new result wins over a status read in the same cycle
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fresh <= 1'b0;
    end else if (word_done) begin
      fresh <= 1'b1;
    end else if (status_rd) begin
      fresh <= 1'b0;
    end
  end

  // read decode; unmapped words read as zero
  always_comb begin
    next_rdata = '0;
    case (AVS_ADDRESS)
      ODF_CTRL_OFS: next_rdata = {28'h0000000, ctrl};
      ODF_STATUS_OFS: begin
        next_rdata[ODF_STAT_SETTLED_BIT] = SETTLED;
        next_rdata[ODF_STAT_RUN_BIT] = run;
        next_rdata[ODF_STAT_FRESH_BIT] = fresh;
      end
      ODF_COUNT_OFS: next_rdata = {25'h0, settle_cnt};
      default: begin
        // result words from 0x20 on, one per channel, sign-extended
        if (AVS_ADDRESS[5] && AVS_ADDRESS[1:0] == 2'b00) begin
          next_rdata = {{8{result[AVS_ADDRESS[4:2]][23]}},
                        result[AVS_ADDRESS[4:2]]};
        end
      end
    endcase
  end

  // one wait cycle per access, then data and acknowledge together
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      AVS_WAITREQUEST <= 1'b1;
    end else if (!AVS_WAITREQUEST) begin
      AVS_WAITREQUEST <= 1'b1;
    end else if (AVS_READ || AVS_WRITE) begin
      AVS_WAITREQUEST <= 1'b0;
    end
  end

  // read data captured as the acknowledge is raised
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      AVS_READDATA <= '0;
    end else if (AVS_WAITREQUEST && AVS_READ) begin
      AVS_READDATA <= next_rdata;
    end
  end
endmodule : odf_filter

// >>> include/odf_pkg.sv
/*
  odf_pkg: constants and types of the eight-channel decimation filter.
  Assumes a single master clock; shared by the filter top and its channel.
*/
package odf_pkg;
  // operating settings, as driven into the control register
  typedef enum logic [1:0] {
    ODF_HIGH_SPEED_SETTING = 2'b00,
    ODF_HIGH_RESOLUTION_SETTING = 2'b01,
    ODF_LOW_POWER_SETTING = 2'b10,
    ODF_LOW_SPEED_SETTING = 2'b11
  } odf_mode_t;

  // result sequencer states
  typedef enum logic [1:0] {
    ODF_IDLE = 2'b00,
    ODF_WALK = 2'b01,
    ODF_COMMIT = 2'b10
  } odf_seq_t;

  localparam int ODF_CHANNELS = 8;
  localparam int ODF_WIDTH = 24;

  // register byte offsets
  localparam logic [5:0] ODF_CTRL_OFS = 6'h00;
  localparam logic [5:0] ODF_STATUS_OFS = 6'h04;
  localparam logic [5:0] ODF_COUNT_OFS = 6'h08;
  localparam logic [5:0] ODF_RESULT_OFS = 6'h20;

  // control fields and reset value
  localparam int ODF_CTRL_MODE_LSB = 0;
  localparam int ODF_CTRL_DIV_BIT = 2;
  localparam int ODF_CTRL_RUN_BIT = 3;
  localparam logic [3:0] ODF_CTRL_RESET = 4'hc;

  // status fields
  localparam int ODF_STAT_SETTLED_BIT = 0;
  localparam int ODF_STAT_RUN_BIT = 1;
  localparam int ODF_STAT_FRESH_BIT = 2;

  // modulator divisors of the master clock
  localparam logic [5:0] ODF_DIV_FAST = 6'h04;
  localparam logic [5:0] ODF_DIV_MID = 6'h08;
  localparam logic [5:0] ODF_DIV_SLOW = 6'h28;

  // oversampling ratios and settling in output periods
  localparam logic [7:0] ODF_OSR_BASE = 8'h40;
  localparam logic [7:0] ODF_OSR_HIRES = 8'h80;
  localparam logic [6:0] ODF_SETTLE_BASE = 7'h4c;
  localparam logic [6:0] ODF_SETTLE_HIRES = 7'h4e;
  localparam logic [6:0] ODF_CIC_SPAN = 7'h04;

  // left shift bringing the comb output to full scale
  localparam logic [2:0] ODF_SHIFT_BASE = 3'h5;
  localparam logic [2:0] ODF_SHIFT_HIRES = 3'h2;

  localparam logic [23:0] ODF_POS_FULL = 24'h7fffff;
  localparam logic [23:0] ODF_NEG_FULL = 24'h800000;
endpackage : odf_pkg

// >>> include/odf_tick_if.sv
/*
  odf_tick_if: common timing strobes from the filter top to each channel.
  Assumes one clock; both ticks are single-cycle, clear is held through a halt, and all strobes are shared by every lane.
*/
`timescale 1ns/1ps
interface odf_tick_if;
  logic mod_tick;
  logic out_tick;
  logic clear;
  modport ctl (output mod_tick, output out_tick, output clear);
  modport filt (input mod_tick, input out_tick, input clear);
endinterface : odf_tick_if

// >>> tb/odf_filter_chk.sv
/*
  odf_filter_chk: port-level assertions for odf_filter.
  Assumes one clock and a control register changed only over the slave port.
*/
`timescale 1ns/1ps
module odf_filter_chk (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // slave port
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // streams and status
  input wire logic [odf_pkg::ODF_CHANNELS-1:0] MOD_BITS,
  input wire logic RESULT_STROBE,
  input wire logic SETTLED
);
  import odf_pkg::*;
  logic [3:0] ctrl;
  logic [11:0] gap;
  logic [11:0] period;
  logic [6:0] words;
  logic gap_ok;
  wire take = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0]
    && AVS_ADDRESS == ODF_CTRL_OFS;
  wire chg = take && AVS_WRITEDATA[3:0] != ctrl;
  wire [6:0] settle = (ctrl[1:0] == 2'b01) ? ODF_SETTLE_HIRES
    : ODF_SETTLE_BASE;
  // shadow of the control register
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) ctrl <= ODF_CTRL_RESET;
    else if (take) ctrl <= AVS_WRITEDATA[3:0];
  end
  // clocks per output word for the shadowed setting
  always_comb begin
    case (ctrl[1:0])
      2'b00: period = 12'h100;
      2'b01: period = 12'h200;
      2'b10: period = ctrl[2] ? 12'h200 : 12'h100;
      default: period = ctrl[2] ? 12'ha00 : 12'h200;
    endcase
  end
  // cycles between strobes, valid only without a setting change
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      gap <= 12'h0;
      gap_ok <= 1'b0;
    end else begin
      gap <= RESULT_STROBE ? 12'h1 : gap + 12'h1;
      gap_ok <= chg ? 1'b0 : (RESULT_STROBE ? 1'b1 : gap_ok);
    end
  end
  // words since the last restart
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) words <= 7'h0;
    else if (chg) words <= 7'h0;
    else if (RESULT_STROBE && words != 7'h7f) words <= words + 7'h1;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  a_wait_answer: assert property (
    $rose(AVS_READ || AVS_WRITE) |=> !AVS_WAITREQUEST)
    else $error("no answer one cycle after request");
  a_wait_once: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low longer than one cycle");
  a_wait_cause: assert property (
    !AVS_WAITREQUEST |-> $past(AVS_READ || AVS_WRITE))
    else $error("answer without request");
  a_rdata_hold: assert property (
    $changed(AVS_READDATA) |-> AVS_READ && !AVS_WAITREQUEST)
    else $error("read data moved outside a read");
  a_strobe_pulse: assert property (
    RESULT_STROBE |=> !RESULT_STROBE)
    else $error("result strobe wider than one cycle");
  a_word_period: assert property (
    RESULT_STROBE && gap_ok |-> gap == period)
    else $error("wrong clocks per output word");
  a_settle_count: assert property (
    $rose(SETTLED) |-> words + 7'h1 >= settle && words <= settle + 7'h1)
    else $error("settled after wrong word count");
  a_halt_quiet: assert property (
    !ctrl[3] && !$past(ctrl[3], 12) |-> !RESULT_STROBE && !SETTLED)
    else $error("activity while held in restart");
  c_strobe: cover property (RESULT_STROBE);
  c_settled: cover property ($rose(SETTLED));
  c_change: cover property (chg);
endmodule : odf_filter_chk

bind odf_filter odf_filter_chk chk (.CLK(CLK), .RESET_N(RESET_N),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .MOD_BITS(MOD_BITS), .RESULT_STROBE(RESULT_STROBE), .SETTLED(SETTLED));

// >>> tb/odf_filter_tb.sv
/*
  odf_filter_tb: register-level bench for odf_filter.
  Assumes one 10 MHz clock and the modulator model as stream source.
*/
`timescale 1ns/1ps
module odf_filter_tb;
  import odf_pkg::*;
  logic clk, reset_n, avs_read, avs_write, avs_wait, strobe, settled;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic [7:0] level, mod_bits;
  int err_total, samples_checked, n, gap;
  logic [3:0] modes [5] = '{4'hd, 4'he, 4'ha, 4'hf, 4'hb};
  int periods [5] = '{512, 512, 256, 2560, 512};
  // master clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  odf_mod_model model (.clk(clk), .reset_n(reset_n), .level(level),
    .bits(mod_bits));
  odf_filter dut (.CLK(clk), .RESET_N(reset_n),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_wait), .MOD_BITS(mod_bits),
    .RESULT_STROBE(strobe), .SETTLED(settled));
  task automatic finish_test;
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_wait !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    check({31'h0, avs_wait}, 32'h0);
  endtask : bus
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rd_chk
  // count strobes; gap ends as the spacing of the last two
  task automatic strobes(input int k);
    int seen;
    seen = 0;
    gap = 0;
    while (seen < k) begin
      @(posedge clk);
      gap++;
      if (strobe === 1'b1) begin
        seen++;
        if (seen < k) gap = 0;
      end
    end
  endtask : strobes
  task automatic wait_settled;
    while (settled !== 1'b1) @(posedge clk);
  endtask : wait_settled
  // watchdog
  initial begin
    #10000000;
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test;
  end
  // main sequence
  initial begin
    err_total = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    level = 8'h55;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rd_chk(ODF_CTRL_OFS, 32'hc);
    rd_chk(ODF_STATUS_OFS, 32'h2);
    bus(1'b1, 6'h10, 32'hffffffff);
    rd_chk(6'h10, 32'h0);
    strobes(20);
    check(32'(gap), 32'h100);
    rd_chk(ODF_RESULT_OFS, 32'h0);
    wait_settled;
    rd_chk(ODF_COUNT_OFS, 32'h4c);
    for (int i = 0; i < 8; i++) begin
      rd_chk(ODF_RESULT_OFS + 6'(4 * i),
             i[0] ? 32'hff800000 : 32'h007fffff);
    end
    // full-scale step on every channel
    level <= 8'haa;
    strobes(28);
    rd_chk(ODF_RESULT_OFS, 32'h007fffff);
    strobes(50);
    rd_chk(ODF_STATUS_OFS, 32'h7);
    rd_chk(ODF_STATUS_OFS, 32'h3);
    rd_chk(ODF_RESULT_OFS, 32'hff800000);
    rd_chk(ODF_RESULT_OFS + 6'h04, 32'h007fffff);
    // high resolution restarts and settles later
    bus(1'b1, ODF_CTRL_OFS, 32'hd);
    bus(1'b0, ODF_STATUS_OFS, 32'h0);
    check(rd & 32'h3, 32'h2);
    wait_settled;
    rd_chk(ODF_COUNT_OFS, 32'h4e);
    rd_chk(ODF_RESULT_OFS + 6'h1c, 32'h007fffff);
    // hold in restart
    bus(1'b1, ODF_CTRL_OFS, 32'h5);
    repeat (20) @(posedge clk);
    bus(1'b0, ODF_STATUS_OFS, 32'h0);
    check(rd & 32'h3, 32'h0);
    rd_chk(ODF_COUNT_OFS, 32'h0);
    // remaining settings and their word spacing
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, ODF_CTRL_OFS, {28'h0, modes[i]});
      rd_chk(ODF_CTRL_OFS, {28'h0, modes[i]});
      strobes(3);
      check(32'(gap), 32'(periods[i]));
    end
    finish_test;
  end
endmodule : odf_filter_tb

// >>> tb/odf_mod_model.sv
/*
  odf_mod_model: eight modulator streams feeding odf_filter.
  Assumes the bench sets a steady density per channel.
*/
`timescale 1ns/1ps
module odf_mod_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // wanted level per channel, 1 = full positive
  input wire logic [7:0] level,
  // one bit per channel toward the filter
  output logic [7:0] bits
);
  // bits launched just after each edge, like a clocked modulator
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) bits <= 8'h00;
    else bits <= level;
  end
endmodule : odf_mod_model
